// File: pkg/rli_pkg.sv
package rli_pkg;

  localparam int unsigned RLI_ADDR_W = 8;
  localparam int unsigned RLI_TIMER_W = 16;
  localparam int unsigned RLI_STEP_W = 3;
  localparam int unsigned RLI_NUM_IN = 7;

  // Register byte offsets
  localparam logic [7:0] RLI_ADDR_ASSIGN = 8'h00;
  localparam logic [7:0] RLI_ADDR_OPEN_TIME = 8'h04;
  localparam logic [7:0] RLI_ADDR_RESET_TIME = 8'h08;
  localparam logic [7:0] RLI_ADDR_SHOTS = 8'h0c;
  localparam logic [7:0] RLI_ADDR_STATUS = 8'h10;
  localparam logic [7:0] RLI_ADDR_LOG = 8'h14;
  localparam logic [7:0] RLI_ADDR_TIMERS = 8'h18;

  // Reset values
  localparam logic [6:0] RLI_RST_ASSIGN = 7'h00;
  localparam logic [15:0] RLI_RST_OPEN_TIME = 16'h0064;
  localparam logic [15:0] RLI_RST_RESET_TIME = 16'h00c8;
  localparam logic [2:0] RLI_RST_SHOTS = 3'h3;

  // Level taken by an input that is not assigned: zone coord high
  localparam logic [6:0] RLI_DEFAULT_LEVELS = 7'h02;

  // Status and timer field positions
  localparam int unsigned RLI_ST_STATE_LSB = 0;
  localparam int unsigned RLI_ST_STEP_LSB = 4;
  localparam int unsigned RLI_ST_OUT_BIT = 8;
  localparam int unsigned RLI_ST_ZSC_BIT = 9;
  localparam int unsigned RLI_ST_LOCK_BIT = 10;
  localparam int unsigned RLI_ST_IN_LSB = 16;
  localparam int unsigned RLI_TM_RESET_LSB = 16;

  typedef struct packed {
    logic trip_reclose_request;
    logic reclose_inhibit;
    logic recloser_enable;
    logic single_shot_enable;
    logic multi_shot_enable;
    logic zone_coord_enable;
    logic spring_charge_monitor;
  } rli_inputs_t;

  typedef enum logic [2:0] {
    RLI_IDLE  = 3'h0,
    RLI_TRIP  = 3'h1,
    RLI_OPEN  = 3'h3,
    RLI_CLOSE = 3'h2,
    RLI_RESET = 3'h6,
    RLI_LOCK  = 3'h7
  } rli_state_t;

endpackage

// File: design/rli_recloser_inputs.sv
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ns
// Summary of operation
// RULE_01: A high trip-reclose request trips the breaker, then starts reclosing.
// RULE_02: A held request keeps tripping and reclosing through successive steps.
// RULE_03: One request pulse gives exactly one trip and reclose.
// RULE_04: An unassigned trip-reclose request reads as low.
// RULE_05: A high reclose inhibit freezes the open timer.
// RULE_06: After inhibit drops, the open timer resumes from its held value.
// RULE_07: Inhibit never affects the reset timer.
// RULE_08: An unassigned reclose inhibit reads as low.
// RULE_09: Recloser works when its enable is high, stops when low.
// RULE_10: A disabled recloser lights the recloser-out indicator.
// RULE_11: An unassigned recloser enable reads as low.
// RULE_12: Single-shot enable plus an external opening gives one reclose.
// RULE_13: An unassigned single-shot enable reads as low.
// RULE_14: Multi-shot enable plus an external opening runs a stepped sequence.
// RULE_15: An unassigned multi-shot enable reads as low.
// RULE_16: Zone coordination follows its enable, which defaults high unassigned.
// RULE_17: A high spring-charge monitor logs a spring-charging event.
// RULE_18: Spring monitor acts only with breaker open; unassigned it reads low.
// RULE_19: Enable loss halts a sequence; return restarts at the first step.
// RULE_20: Shot enables are sampled only when a breaker opening is detected.
// RULE_21: Inputs are synchronised; the request is edge and level tracked.
module rli_recloser_inputs
  import rli_pkg::*;
#(
  parameter int unsigned TW = RLI_TIMER_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [RLI_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trip_reclose_request,
  input wire logic reclose_inhibit,
  input wire logic recloser_enable_input,
  input wire logic single_shot_enable,
  input wire logic multi_shot_enable,
  input wire logic zone_coord_enable,
  input wire logic spring_charge_monitor,
  input wire logic breaker_open,
  output logic breaker_trip,
  output logic breaker_close,
  output logic recloser_out_led,
  output logic zone_coord_active,
  output logic spring_event,
  output logic lockout,
  output logic [RLI_STEP_W-1:0] recloser_step
);

  ////////////////////////////////////////////////////////////////////////
  logic [6:0] assign_ff;
  logic [TW-1:0] open_time_ff, reset_time_ff, open_cnt_ff, rst_cnt_ff;
  logic [RLI_STEP_W-1:0] shots_ff, step_ff, nxt_step;
  logic [15:0] log_cnt_ff;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, pslverr_ff, nxt_pslverr, wr_en;

  rli_inputs_t in_raw, in_eff, sync1_ff, sync2_ff, prev_ff;
  logic brk1_ff, brk2_ff, brk_prev_ff;
  rli_state_t state_ff, nxt_state;
  logic single_ff, nxt_single;

  logic trip_ff, close_ff, out_led_ff, zone_ff, spring_ff, lock_ff;
  logic scc_act_prev_ff;
  logic en, trip_reclose_request_rise, brk_rise, brk_fall, ext_open;
  logic open_done, rst_done, last_step, scc_act;

  ////////////////////////////////////////////////////////////////////////
  assign in_raw = '{trip_reclose_request, reclose_inhibit,
                    recloser_enable_input, single_shot_enable,
                    multi_shot_enable, zone_coord_enable,
                    spring_charge_monitor};

  // Unassigned inputs take their fixed level instead of the pin
  genvar gi;
  generate
    for (gi = 0; gi < RLI_NUM_IN; gi++) begin : g_in
      // RULE_04 RULE_08 RULE_11 RULE_13 RULE_15 RULE_16 RULE_18
      assign in_eff[gi] = assign_ff[gi] ? in_raw[gi] : RLI_DEFAULT_LEVELS[gi];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_ff[gi] <= RLI_DEFAULT_LEVELS[gi];
          sync2_ff[gi] <= RLI_DEFAULT_LEVELS[gi];
          prev_ff[gi] <= RLI_DEFAULT_LEVELS[gi];
        end else begin
          sync1_ff[gi] <= in_eff[gi]; // RULE_21
          sync2_ff[gi] <= sync1_ff[gi];
          prev_ff[gi] <= sync2_ff[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk1_ff <= 1'h0;
      brk2_ff <= 1'h0;
      brk_prev_ff <= 1'h0;
    end else begin
      brk1_ff <= breaker_open;
      brk2_ff <= brk1_ff;
      brk_prev_ff <= brk2_ff;
    end
  end

  assign en = sync2_ff.recloser_enable; // RULE_09
  // Edge gives the single operation, level keeps a held request going
  assign trip_reclose_request_rise = sync2_ff.trip_reclose_request &
                     ~prev_ff.trip_reclose_request; // RULE_21
  assign brk_rise = brk2_ff & ~brk_prev_ff;
  assign brk_fall = ~brk2_ff & brk_prev_ff;
  // Only an opening we did not command counts as external
  assign ext_open = brk_rise &
                    (state_ff == RLI_IDLE || state_ff == RLI_RESET);
  assign open_done = open_cnt_ff >= open_time_ff;
  assign rst_done = rst_cnt_ff >= reset_time_ff;
  assign last_step = (step_ff + 3'h1) >= shots_ff;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_single = single_ff;
    unique case (state_ff)
      RLI_IDLE: begin
        nxt_step = 3'h0;
        if (trip_reclose_request_rise) begin
          nxt_state = RLI_TRIP; // RULE_01 RULE_03
          nxt_single = 1'h0;
        end else if (ext_open) begin
          // Shot enables looked at only here
          if (sync2_ff.multi_shot_enable) begin
            nxt_state = RLI_OPEN; // RULE_14 RULE_20
            nxt_single = 1'h0;
          end else if (sync2_ff.single_shot_enable) begin
            nxt_state = RLI_OPEN; // RULE_12 RULE_20
            nxt_single = 1'h1;
          end
        end
      end
      RLI_TRIP: begin
        if (brk2_ff) begin
          nxt_state = (step_ff >= shots_ff) ? RLI_LOCK : RLI_OPEN;
        end
      end
      RLI_OPEN: begin
        // No reclose while inhibited, even if the timer has already expired
        if (open_done && !sync2_ff.reclose_inhibit) begin // RULE_05
          nxt_state = RLI_CLOSE;
        end
      end
      RLI_CLOSE: begin
        if (!brk2_ff) begin
          nxt_state = RLI_RESET;
        end
      end
      RLI_RESET: begin
        if (rst_done) begin
          nxt_state = RLI_IDLE;
        end else if (ext_open) begin
          nxt_state = (single_ff || last_step) ? RLI_LOCK : RLI_OPEN;
          nxt_step = step_ff + 3'h1; // RULE_14
        end else if (sync2_ff.trip_reclose_request) begin
          nxt_state = RLI_TRIP; // RULE_02
          nxt_step = step_ff + 3'h1;
        end
      end
      RLI_LOCK: begin
        // Leaves when the breaker is closed by hand, or when the recloser enable drops
        if (brk_fall) begin
          nxt_state = RLI_IDLE;
        end
      end
      default: begin
        nxt_state = RLI_IDLE;
      end
    endcase
    if (!en) begin
      nxt_state = RLI_IDLE; // RULE_09 RULE_19
      nxt_step = 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RLI_IDLE;
      step_ff <= 3'h0;
      single_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      single_ff <= nxt_single;
    end
  end

  // Open timer: held, not cleared, while inhibited
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_cnt_ff <= '0;
    end else if (nxt_state != RLI_OPEN) begin
      open_cnt_ff <= '0;
    end else if (state_ff == RLI_OPEN && !sync2_ff.reclose_inhibit) begin
      open_cnt_ff <= open_cnt_ff + TW'(1); // RULE_05 RULE_06
    end
  end

  // Reset timer ignores the inhibit input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_ff <= '0;
    end else if (nxt_state != RLI_RESET || state_ff != RLI_RESET) begin
      rst_cnt_ff <= '0;
    end else begin
      rst_cnt_ff <= rst_cnt_ff + TW'(1); // RULE_07
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign scc_act = sync2_ff.spring_charge_monitor & brk2_ff; // RULE_18

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_ff <= 1'h0;
      close_ff <= 1'h0;
      out_led_ff <= 1'h1;
      zone_ff <= 1'h1;
      spring_ff <= 1'h0;
      scc_act_prev_ff <= 1'h0;
      lock_ff <= 1'h0;
    end else begin
      trip_ff <= nxt_state == RLI_TRIP; // RULE_01
      close_ff <= nxt_state == RLI_CLOSE;
      out_led_ff <= ~en; // RULE_10
      zone_ff <= sync2_ff.zone_coord_enable; // RULE_16
      spring_ff <= scc_act & ~scc_act_prev_ff; // RULE_17
      scc_act_prev_ff <= scc_act;
      lock_ff <= nxt_state == RLI_LOCK;
    end
  end

  assign breaker_trip = trip_ff;
  assign breaker_close = close_ff;
  assign recloser_out_led = out_led_ff;
  assign zone_coord_active = zone_ff;
  assign spring_event = spring_ff;
  assign lockout = lock_ff;
  assign recloser_step = step_ff;

  ////////////////////////////////////////////////////////////////////////
  // APB: no wait states; every answer comes from a flop loaded in the setup phase
  assign wr_en = psel & penable & pready_ff & pwrite;

  always_comb begin
    nxt_prdata = 32'h0;
    nxt_pslverr = 1'h0;
    unique case (paddr)
      RLI_ADDR_ASSIGN: nxt_prdata[6:0] = assign_ff;
      RLI_ADDR_OPEN_TIME: nxt_prdata[TW-1:0] = open_time_ff;
      RLI_ADDR_RESET_TIME: nxt_prdata[TW-1:0] = reset_time_ff;
      RLI_ADDR_SHOTS: nxt_prdata[RLI_STEP_W-1:0] = shots_ff;
      RLI_ADDR_STATUS: begin
        nxt_prdata[RLI_ST_STATE_LSB +: 3] = state_ff;
        nxt_prdata[RLI_ST_STEP_LSB +: RLI_STEP_W] = step_ff;
        nxt_prdata[RLI_ST_OUT_BIT] = out_led_ff;
        nxt_prdata[RLI_ST_ZSC_BIT] = zone_ff;
        nxt_prdata[RLI_ST_LOCK_BIT] = lock_ff;
        nxt_prdata[RLI_ST_IN_LSB +: RLI_NUM_IN] = sync2_ff;
      end
      RLI_ADDR_LOG: nxt_prdata[15:0] = log_cnt_ff;
      RLI_ADDR_TIMERS: begin
        nxt_prdata[TW-1:0] = open_cnt_ff;
        nxt_prdata[RLI_TM_RESET_LSB +: TW] = rst_cnt_ff;
      end
      default: nxt_pslverr = 1'h1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'h0;
      pslverr_ff <= 1'h0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= psel & ~penable;
      if (psel && !penable) begin
        prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
        pslverr_ff <= nxt_pslverr;
      end else begin
        pslverr_ff <= 1'h0;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      assign_ff <= RLI_RST_ASSIGN;
      open_time_ff <= TW'(RLI_RST_OPEN_TIME);
      reset_time_ff <= TW'(RLI_RST_RESET_TIME);
      shots_ff <= RLI_RST_SHOTS;
    end else if (wr_en) begin
      if (paddr == RLI_ADDR_ASSIGN) assign_ff <= pwdata[6:0];
      if (paddr == RLI_ADDR_OPEN_TIME) open_time_ff <= pwdata[TW-1:0];
      if (paddr == RLI_ADDR_RESET_TIME) reset_time_ff <= pwdata[TW-1:0];
      if (paddr == RLI_ADDR_SHOTS) shots_ff <= pwdata[RLI_STEP_W-1:0];
    end
  end

  // Spring log: a write to the log register clears it, but a same-cycle event still counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_cnt_ff <= 16'h0;
    end else if (wr_en && paddr == RLI_ADDR_LOG) begin
      log_cnt_ff <= {15'h0, spring_ff};
    end else if (spring_ff) begin
      log_cnt_ff <= log_cnt_ff + 16'h1; // RULE_17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_trip_on_req: assert property ( // RULE_01
    state_ff == RLI_IDLE && en && trip_reclose_request_rise |=> breaker_trip)
    else $error("request did not trip");
  a_held_next_step: assert property ( // RULE_02
    state_ff == RLI_RESET && en && !rst_done && !ext_open &&
    sync2_ff.trip_reclose_request |=>
    state_ff == RLI_TRIP && step_ff == $past(step_ff) + 3'h1)
    else $error("held request did not step");
  a_idle_no_edge: assert property ( // RULE_03
    state_ff == RLI_IDLE && !trip_reclose_request_rise && !ext_open |=>
    state_ff == RLI_IDLE && !breaker_trip)
    else $error("operation without a pulse");
  a_inhibit_hold: assert property ( // RULE_05
    state_ff == RLI_OPEN && sync2_ff.reclose_inhibit && en |=>
    open_cnt_ff == $past(open_cnt_ff))
    else $error("open timer ran while inhibited");
  a_open_resume: assert property ( // RULE_06
    state_ff == RLI_OPEN && nxt_state == RLI_OPEN &&
    !sync2_ff.reclose_inhibit |=> open_cnt_ff == $past(open_cnt_ff) + TW'(1))
    else $error("open timer did not resume");
  a_reset_free: assert property ( // RULE_07
    state_ff == RLI_RESET && nxt_state == RLI_RESET |=>
    rst_cnt_ff == $past(rst_cnt_ff) + TW'(1))
    else $error("reset timer stalled");
  a_disable_halt: assert property ( // RULE_19
    !en |=> state_ff == RLI_IDLE && step_ff == 3'h0 && recloser_out_led)
    else $error("disable did not halt recloser");
  a_single_lock: assert property ( // RULE_12
    state_ff == RLI_RESET && single_ff && ext_open && en && !rst_done
    |=> state_ff == RLI_LOCK && lockout)
    else $error("single shot reclosed twice");
  a_zone_default: assert property ( // RULE_16
    !assign_ff[1] [*3] |=> zone_coord_active)
    else $error("zone coord default not high");
  a_spring_open: assert property ( // RULE_18
    spring_event |-> $past(brk2_ff))
    else $error("spring event with breaker closed");

endmodule

// File: verification/rli_breaker_model.sv
`timescale 1ns/1ns
// Behavioural breaker: follows trip and close after DLY+1 cycles of travel
module rli_breaker_model #(
  parameter int unsigned DLY = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic breaker_trip,
  input wire logic breaker_close,
  input wire logic ext_open,
  input wire logic ext_close,
  output logic breaker_open
);
  logic open_ff;
  logic [3:0] cnt_ff;
  assign breaker_open = open_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_ff <= 1'b0;
      cnt_ff <= 4'h0;
    end else if (ext_open) begin
      open_ff <= 1'b1;
    end else if (ext_close) begin
      open_ff <= 1'b0;
    end else if ((breaker_trip && !open_ff) || (breaker_close && open_ff)) begin
      // Mechanism needs time: contacts move only after DLY+1 cycles
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == DLY[3:0]) begin
        open_ff <= !open_ff;
        cnt_ff <= 4'h0;
      end
    end else begin
      cnt_ff <= 4'h0;
    end
  end
endmodule

// File: verification/rli_recloser_inputs_tb.sv
`timescale 1ns/1ns
module rli_recloser_inputs_tb;
  import rli_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] held;
  logic err, breaker_open, breaker_trip, breaker_close, recloser_out_led;
  logic zone_coord_active, spring_event, lockout, ext_open, ext_close, trip_q;
  logic [2:0] recloser_step;
  rli_inputs_t pin;
  int num_errors, n_compared, trips, springs;
  // Row: address, expected read data, expected error flag
  logic [40:0] rows [8] = '{{8'h00, 32'h0, 1'b0}, {8'h04, 32'h64, 1'b0},
    {8'h08, 32'hc8, 1'b0}, {8'h0c, 32'h3, 1'b0}, {8'h14, 32'h0, 1'b0},
    {8'h10, 32'h00020300, 1'b0}, {8'h18, 32'h0, 1'b0},
    {8'h1c, 32'h0, 1'b1}};

  rli_recloser_inputs dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trip_reclose_request(pin.trip_reclose_request),
    .reclose_inhibit(pin.reclose_inhibit),
    .recloser_enable_input(pin.recloser_enable),
    .single_shot_enable(pin.single_shot_enable),
    .multi_shot_enable(pin.multi_shot_enable),
    .zone_coord_enable(pin.zone_coord_enable),
    .spring_charge_monitor(pin.spring_charge_monitor),
    .breaker_open(breaker_open), .breaker_trip(breaker_trip),
    .breaker_close(breaker_close), .recloser_out_led(recloser_out_led),
    .zone_coord_active(zone_coord_active), .spring_event(spring_event),
    .lockout(lockout), .recloser_step(recloser_step));

  rli_breaker_model brk (.pclk(pclk), .presetn(presetn),
    .breaker_trip(breaker_trip), .breaker_close(breaker_close),
    .ext_open(ext_open), .ext_close(ext_close), .breaker_open(breaker_open));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    trip_q <= breaker_trip;
    if (breaker_trip === 1'b1 && trip_q === 1'b0) trips++;
    if (spring_event === 1'b1) springs++;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      tally_and_finish();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait on one of the outputs watched by the bench
  task automatic wait_sig(input int idx, input logic v);
    int n;
    logic [4:0] mon;
    n = 0;
    do begin
      @(posedge pclk);
      mon = {lockout, spring_event, breaker_close, breaker_trip,
        breaker_open};
      n++;
    end while (mon[idx] !== v && n < 2000);
    if (n >= 2000) begin
      num_errors++;
      tally_and_finish();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin = '0;
    ext_open = 1'b0;
    ext_close = 1'b0;
    trip_q = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(recloser_out_led, 1'b1);
    chk(zone_coord_active, 1'b1);
    foreach (rows[i]) begin
      apb(1'b0, rows[i][40:33], 32'h0);
      chk(q, rows[i][32:1]);
      chk(err, rows[i][0]);
    end
    $display("register reset test done");
    // Pins are ignored until assigned
    pin.trip_reclose_request <= 1'b1;
    pin.recloser_enable <= 1'b1;
    pin.reclose_inhibit <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(trips, 0);
    chk(recloser_out_led, 1'b1);
    pin <= '0;
    apb(1'b1, 8'h00, 32'h7f);
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b1, 8'h08, 32'h8);
    pin.recloser_enable <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(recloser_out_led, 1'b0);
    chk(zone_coord_active, 1'b0);
    $display("assignment test done");
    // One short pulse gives one trip and one reclose
    pin.trip_reclose_request <= 1'b1;
    @(posedge pclk);
    pin.trip_reclose_request <= 1'b0;
    wait_sig(1, 1'b1);
    wait_sig(2, 1'b1);
    wait_sig(2, 1'b0);
    repeat (40) @(posedge pclk);
    chk(trips, 1);
    chk(recloser_step, 3'h0);
    $display("pulse test done");
    // Inhibit mid open time: timer frozen, then resumes to a close
    pin.trip_reclose_request <= 1'b1;
    @(posedge pclk);
    pin.trip_reclose_request <= 1'b0;
    wait_sig(0, 1'b1);
    // Let the open timer run two cycles so the frozen value is not zero
    repeat (2) @(posedge pclk);
    pin.reclose_inhibit <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, 8'h18, 32'h0);
    held = q[15:0];
    repeat (10) @(posedge pclk);
    apb(1'b0, 8'h18, 32'h0);
    chk(held, 16'h0002);
    chk(q[15:0], held);
    chk(breaker_close, 1'b0);
    pin.reclose_inhibit <= 1'b0;
    wait_sig(2, 1'b1);
    wait_sig(2, 1'b0);
    chk(trips, 2);
    $display("inhibit test done");
    // Held request steps on until lockout
    pin.trip_reclose_request <= 1'b1;
    wait_sig(4, 1'b1);
    chk(trips, 5);
    chk(recloser_step, RLI_RST_SHOTS);
    pin.trip_reclose_request <= 1'b0;
    pin.recloser_enable <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(recloser_out_led, 1'b1);
    chk(recloser_step, 3'h0);
    chk(lockout, 1'b0);
    $display("held and disable test done");
    // External opening with single shot; spring monitor only while open
    ext_close <= 1'b1;
    pin.recloser_enable <= 1'b1;
    pin.spring_charge_monitor <= 1'b1;
    @(posedge pclk);
    ext_close <= 1'b0;
    // Monitor rises while the breaker still reads open: let that event pass
    repeat (10) @(posedge pclk);
    apb(1'b1, 8'h14, 32'h0);
    springs = 0;
    pin.single_shot_enable <= 1'b1;
    @(posedge pclk);
    ext_open <= 1'b1;
    @(posedge pclk);
    ext_open <= 1'b0;
    wait_sig(2, 1'b1);
    wait_sig(2, 1'b0);
    // Reopened inside the reset time: a single shot locks out instead
    ext_open <= 1'b1;
    @(posedge pclk);
    ext_open <= 1'b0;
    wait_sig(4, 1'b1);
    chk(breaker_close, 1'b0);
    ext_close <= 1'b1;
    @(posedge pclk);
    ext_close <= 1'b0;
    wait_sig(4, 1'b0);
    repeat (20) @(posedge pclk);
    chk(springs, 2);
    apb(1'b0, 8'h14, 32'h0);
    chk(q[15:0], 16'h0002);
    $display("external opening test done");
    // Multi shot steps on when reopened inside the reset time
    pin.single_shot_enable <= 1'b0;
    pin.multi_shot_enable <= 1'b1;
    repeat (3) @(posedge pclk);
    ext_open <= 1'b1;
    @(posedge pclk);
    ext_open <= 1'b0;
    wait_sig(2, 1'b1);
    wait_sig(2, 1'b0);
    ext_open <= 1'b1;
    @(posedge pclk);
    ext_open <= 1'b0;
    wait_sig(2, 1'b1);
    chk(recloser_step, 3'h1);
    wait_sig(2, 1'b0);
    chk(lockout, 1'b0);
    $display("multi shot test done");
    tally_and_finish();
  end

  initial begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end
endmodule
